// [inc/rlf_pkg.sv]
// constants, register map and types of the radio link frame control block
package rlf_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_TMO = 8'h04;
  localparam logic [7:0] A_ARP = 8'h08;
  localparam logic [7:0] A_GAP = 8'h0c;
  localparam logic [7:0] A_ACKW = 8'h10;
  localparam logic [7:0] A_BLK = 8'h14;
  localparam logic [7:0] A_RATE = 8'h18;
  localparam logic [7:0] A_STAT = 8'h1c;
  // ****************************************
  // control field positions
  // ****************************************
  localparam int F_ACK = 0;
  localparam int F_TMO = 1;
  localparam int F_RPT = 2;
  localparam int F_STRM = 3;
  localparam int F_FEC = 4;
  localparam int F_RTY = 8;
  localparam int F_QLEN = 12;
  localparam int F_QSZ = 17;
  localparam int F_RELAY = 24;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [3:0] RST_RETRIES = 4'h3;
  localparam logic [4:0] RST_QLEN = 5'h05;
  localparam logic [5:0] RST_QSIZE_KB = 6'h05;
  localparam logic [13:0] RST_TMO = 14'h01f4;
  localparam logic [11:0] RST_ARP_MIN = 12'h5a0;
  localparam logic [15:0] RST_GAP = 16'h0fa0;
  localparam logic [15:0] RST_BYTE_T = 16'h0100;
  localparam logic [15:0] RST_ACKW = 16'h1000;
  localparam logic [15:0] RST_BLK = 16'h0800;
  localparam logic [15:0] RST_RATE = 16'h0040;
  localparam logic [15:0] RST_DUP_HOLD = 16'hffff;
  localparam logic [16:0] KB_BYTES = 17'h00400;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 40;
  localparam int TMO_STEP_MS = 10;
  localparam int TMO_STEP_CYC = TMO_STEP_MS * 1000000 / CLK_PERIOD_NS;
  localparam longint MINUTE_S = 60;
  localparam longint MINUTE_CYC = MINUTE_S * 64'd1000000000 / CLK_PERIOD_NS;
  // ****************************************
  // transmit engine states
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SEND = 4'b0010,
    ST_ACKW = 4'b0100,
    ST_HOLD = 4'b1000
  } rlf_tx_e;
endpackage

// [src/rlf_frame_ctrl.sv]
// transmit queue, acknowledge engine and bridge forwarding of the radio link
module rlf_frame_ctrl #(
  parameter int DEPTH = 31,
  parameter int DUP_N = 4,
  parameter int TICK_CYCLES = rlf_pkg::TMO_STEP_CYC,
  parameter int MIN_CYCLES = int'(rlf_pkg::MINUTE_CYC)
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // user ingress
  input wire logic eth_valid_i,
  input wire logic [15:0] eth_len_i,
  input wire logic [1:0] ser_byte_valid_i,
  input wire logic [15:0] ser_data_i,
  // radio transmit
  output logic tx_start_o,
  output logic [15:0] tx_len_o,
  output logic [1:0] tx_src_o,
  input wire logic tx_done_i,
  input wire logic ack_rx_i,
  output logic arp_tx_o,
  // radio receive
  input wire logic rx_valid_i,
  input wire logic rx_crc_ok_i,
  input wire logic rx_local_i,
  input wire logic [15:0] rx_sig_i,
  input wire logic [15:0] rx_len_i,
  input wire logic rx_byte_valid_i,
  input wire logic [7:0] rx_byte_i,
  output logic rx_eth_o,
  output logic rx_ser_o,
  output logic [1:0] ser_out_valid_o,
  output logic [7:0] ser_out_data_o,
  // stream and events
  output logic stream_byte_o,
  output logic stream_first_o,
  output logic [7:0] stream_data_o,
  output logic stream_abort_o,
  output logic refused_o,
  output logic drop_o
);
  // ****************************************
  // registers
  // ****************************************
  logic ack_en, tmo_en, rpt_en, strm_en;
  logic [1:0] fec_sel;
  logic [3:0] retries;
  logic [4:0] qlen;
  logic [5:0] qsize_kb;
  logic [3:0] network_relay_count;
  logic [13:0] tmo;
  logic [11:0] arp_min;
  logic [15:0] idle_gap, byte_time, ackw, blk, mod_rate;
  logic [15:0] user_rate;
  logic [7:0] reject_cnt;
  logic apb_wr;
  logic [31:0] next_rdata;
  logic addr_ok;

  assign apb_wr = psel_i && penable_i && pready_o && pwrite_i;
  assign addr_ok = paddr_i[7:5] == 3'h0 && paddr_i[1:0] == 2'h0;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      ack_en <= 1'b1;
      tmo_en <= 1'b0;
      rpt_en <= 1'b0;
      strm_en <= 1'b0;
      fec_sel <= 2'h0;
      retries <= rlf_pkg::RST_RETRIES;
      qlen <= rlf_pkg::RST_QLEN;
      qsize_kb <= rlf_pkg::RST_QSIZE_KB;
      network_relay_count <= 4'h0;
      tmo <= rlf_pkg::RST_TMO;
      arp_min <= rlf_pkg::RST_ARP_MIN;
      idle_gap <= rlf_pkg::RST_GAP;
      byte_time <= rlf_pkg::RST_BYTE_T;
      ackw <= rlf_pkg::RST_ACKW;
      blk <= rlf_pkg::RST_BLK;
      mod_rate <= rlf_pkg::RST_RATE;
    end else if (apb_wr) begin
      unique case (paddr_i)
        rlf_pkg::A_CTRL: begin
          ack_en <= pwdata_i[rlf_pkg::F_ACK];
          tmo_en <= pwdata_i[rlf_pkg::F_TMO];
          rpt_en <= pwdata_i[rlf_pkg::F_RPT];
          strm_en <= pwdata_i[rlf_pkg::F_STRM];
          fec_sel <= pwdata_i[rlf_pkg::F_FEC +: 2];
          retries <= pwdata_i[rlf_pkg::F_RTY +: 4];
          qlen <= pwdata_i[rlf_pkg::F_QLEN +: 5];
          qsize_kb <= pwdata_i[rlf_pkg::F_QSZ +: 6];
          network_relay_count <= pwdata_i[rlf_pkg::F_RELAY +: 4];
        end
        rlf_pkg::A_TMO: tmo <= pwdata_i[13:0];
        rlf_pkg::A_ARP: arp_min <= pwdata_i[11:0];
        rlf_pkg::A_GAP: begin
          idle_gap <= pwdata_i[15:0];
          byte_time <= pwdata_i[31:16];
        end
        rlf_pkg::A_ACKW: ackw <= pwdata_i[15:0];
        rlf_pkg::A_BLK: blk <= pwdata_i[15:0];
        rlf_pkg::A_RATE: mod_rate <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // ratio in eighths: off, 7/8, 3/4, 1/2
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      user_rate <= 16'h0000;
    end else begin
      unique case (fec_sel)
        2'h0: user_rate <= mod_rate;
        2'h1: user_rate <= 16'((20'(mod_rate) * 20'h7) >> 3);
        2'h2: user_rate <= 16'((20'(mod_rate) * 20'h6) >> 3);
        default: user_rate <= 16'(mod_rate >> 1);
      endcase
    end
  end

  // ****************************************
  // queue of frame records
  // ****************************************
  logic [15:0] q_len [DEPTH];
  logic [13:0] q_age [DEPTH];
  logic [1:0] q_src [DEPTH];
  logic [4:0] q_cnt;
  logic [16:0] q_bytes;
  logic q_full, push, pop, tick;
  logic [15:0] push_len;
  logic [1:0] push_src;
  logic [4:0] wr_idx;

  // full on the qlen record limit, the DEPTH limit or the byte limit, whichever is reached first
  assign q_full = q_cnt >= qlen || 5'(q_cnt) >= 5'(DEPTH)
    || q_bytes >= 17'(qsize_kb) * rlf_pkg::KB_BYTES;
  assign wr_idx = pop ? q_cnt - 5'h1 : q_cnt;

  for (genvar i = 0; i < DEPTH; i++) begin : g_q
    logic [13:0] aged;
    if (i < DEPTH - 1) begin : g_up
      assign aged = pop ? q_age[i + 1] : q_age[i];
    end else begin : g_top
      assign aged = q_age[i];
    end
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        q_len[i] <= 16'h0000;
        q_age[i] <= 14'h0000;
        q_src[i] <= 2'h0;
      end else if (push && wr_idx == 5'(i)) begin
        q_len[i] <= push_len;
        q_age[i] <= 14'h0000;
        q_src[i] <= push_src;
      end else begin
        if (pop && i < DEPTH - 1) begin
          q_len[i] <= q_len[(i + 1) % DEPTH];
          q_src[i] <= q_src[(i + 1) % DEPTH];
        end
        q_age[i] <= (tick && aged != 14'h3fff) ? aged + 14'h1 : aged;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      q_cnt <= 5'h00;
      q_bytes <= 17'h00000;
    end else begin
      q_cnt <= q_cnt + 5'(push) - 5'(pop);
      q_bytes <= q_bytes + (push ? 17'(push_len) : 17'h0) - (pop ? 17'(q_len[0]) : 17'h0);
    end
  end

  // ****************************************
  // ingress: relay, ethernet, serial idle framing
  // ****************************************
  logic relay_req, eth_take;
  logic [1:0] ser_open, ser_close, ser_take;
  logic [15:0] ser_gap [2];
  logic [15:0] ser_cnt [2];

  for (genvar p = 0; p < 2; p++) begin : g_ser
    assign ser_close[p] = !strm_en && ser_open[p] && ser_gap[p] > idle_gap;
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        ser_open[p] <= 1'b0;
        ser_gap[p] <= 16'h0000;
        ser_cnt[p] <= 16'h0000;
      end else if (ser_take[p]) begin
        ser_open[p] <= 1'b0;
        ser_cnt[p] <= 16'h0000;
      end else if (ser_byte_valid_i[p] && !strm_en) begin
        ser_open[p] <= 1'b1;
        ser_gap[p] <= 16'h0000;
        ser_cnt[p] <= ser_cnt[p] + 16'h1;
      end else if (ser_open[p] && ser_gap[p] != 16'hffff) begin
        ser_gap[p] <= ser_gap[p] + 16'h1;
      end
    end
  end

  always_comb begin
    push = 1'b0;
    push_len = 16'h0000;
    push_src = 2'h0;
    eth_take = 1'b0;
    ser_take = 2'b00;
    // a closed serial frame is taken (or refused) only when nothing else competes
    if (relay_req) begin
      push = !q_full;
      push_len = rx_len_i;
      push_src = 2'h3;
    end else if (eth_valid_i) begin
      eth_take = 1'b1;
      push = !q_full;
      push_len = eth_len_i;
    end else if (ser_close[0]) begin
      ser_take[0] = 1'b1;
      push = !q_full;
      push_len = ser_cnt[0];
      push_src = 2'h1;
    end else if (ser_close[1]) begin
      ser_take[1] = 1'b1;
      push = !q_full;
      push_len = ser_cnt[1];
      push_src = 2'h2;
    end
  end

  // ****************************************
  // receive path, duplicate store
  // ****************************************
  logic relay_on, dup_hit, rx_ok;
  logic [DUP_N-1:0] dup_v, dup_m;
  logic [15:0] dup_sig [DUP_N];
  logic [15:0] dup_t [DUP_N];
  logic [$clog2(DUP_N)-1:0] dup_ptr;

  assign relay_on = network_relay_count != 4'h0;
  assign dup_hit = relay_on && |dup_m;
  assign rx_ok = rx_valid_i && rx_crc_ok_i && !dup_hit;
  assign relay_req = rx_ok && rpt_en;

  for (genvar d = 0; d < DUP_N; d++) begin : g_dup
    assign dup_m[d] = dup_v[d] && dup_sig[d] == rx_sig_i;
    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        dup_v[d] <= 1'b0;
        dup_sig[d] <= 16'h0000;
        dup_t[d] <= 16'h0000;
      end else if (rx_ok && relay_on && int'(dup_ptr) == d) begin
        dup_v[d] <= 1'b1;
        dup_sig[d] <= rx_sig_i;
        dup_t[d] <= rlf_pkg::RST_DUP_HOLD;
      end else if (dup_t[d] != 16'h0000) begin
        dup_t[d] <= dup_t[d] - 16'h1;
      end else begin
        dup_v[d] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      dup_ptr <= '0;
      rx_eth_o <= 1'b0;
      rx_ser_o <= 1'b0;
      ser_out_valid_o <= 2'b00;
      ser_out_data_o <= 8'h00;
    end else begin
      if (rx_ok && relay_on) begin
        dup_ptr <= dup_ptr + ($clog2(DUP_N))'(1);
      end
      rx_eth_o <= rx_ok && rx_local_i;
      rx_ser_o <= rx_ok;
      ser_out_valid_o <= {2{strm_en && rx_byte_valid_i}};
      ser_out_data_o <= rx_byte_i;
    end
  end

  // ****************************************
  // stream mode
  // ****************************************
  logic [15:0] byte_tmr;
  logic strm_byte;
  assign strm_byte = strm_en && |ser_byte_valid_i;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      byte_tmr <= 16'h0000;
      stream_byte_o <= 1'b0;
      stream_first_o <= 1'b0;
      stream_data_o <= 8'h00;
      stream_abort_o <= 1'b0;
    end else begin
      stream_byte_o <= strm_byte;
      stream_abort_o <= strm_en && eth_valid_i && byte_tmr != 16'h0000;
      if (strm_byte) begin
        stream_first_o <= byte_tmr == 16'h0000;
        stream_data_o <= ser_byte_valid_i[0] ? ser_data_i[7:0] : ser_data_i[15:8];
        byte_tmr <= byte_time;
      end else if (strm_en && eth_valid_i) begin
        byte_tmr <= 16'h0000;
      end else if (byte_tmr != 16'h0000) begin
        byte_tmr <= byte_tmr - 16'h1;
      end
    end
  end

  // ****************************************
  // transmit engine
  // ****************************************
  rlf_pkg::rlf_tx_e state;
  logic [3:0] tries_left;
  logic [15:0] ack_tmr;
  logic [19:0] blk_tmr;
  logic tmo_drop, tx_fin;

  // frames wait in order, so the head is always the oldest
  assign tmo_drop = tmo_en && state == rlf_pkg::ST_IDLE && q_cnt != 5'h00
    && q_age[0] >= tmo;
  assign pop = tmo_drop || tx_fin;
  assign tx_fin = (state == rlf_pkg::ST_SEND && tx_done_i && !ack_en)
    || (state == rlf_pkg::ST_ACKW && (ack_rx_i
    || (ack_tmr == 16'h0000 && tries_left == 4'h0)));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= rlf_pkg::ST_IDLE;
      tries_left <= 4'h0;
      ack_tmr <= 16'h0000;
      tx_start_o <= 1'b0;
      tx_len_o <= 16'h0000;
      tx_src_o <= 2'h0;
    end else begin
      tx_start_o <= 1'b0;
      unique case (state)
        rlf_pkg::ST_IDLE: begin
          // no carrier sensing: the head goes as soon as blocking allows
          if (q_cnt != 5'h00 && !tmo_drop && blk_tmr == 20'h00000) begin
            tx_start_o <= 1'b1;
            tx_len_o <= q_len[0];
            tx_src_o <= q_src[0];
            tries_left <= ack_en ? retries : 4'h0;
            state <= rlf_pkg::ST_SEND;
          end
        end
        rlf_pkg::ST_SEND: begin
          if (tx_done_i) begin
            ack_tmr <= ackw;
            state <= ack_en ? rlf_pkg::ST_ACKW : rlf_pkg::ST_HOLD;
          end
        end
        rlf_pkg::ST_ACKW: begin
          if (ack_rx_i || (ack_tmr == 16'h0000 && tries_left == 4'h0)) begin
            state <= rlf_pkg::ST_HOLD;
          end else if (ack_tmr == 16'h0000) begin
            tries_left <= tries_left - 4'h1;
            tx_start_o <= 1'b1;
            state <= rlf_pkg::ST_SEND;
          end else begin
            ack_tmr <= ack_tmr - 16'h1;
          end
        end
        rlf_pkg::ST_HOLD: state <= rlf_pkg::ST_IDLE;
      endcase
    end
  end

  // quiet period after each own transmission or accepted good reception, none without relays
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      blk_tmr <= 20'h00000;
    end else if (relay_on && ((state == rlf_pkg::ST_SEND && tx_done_i) || rx_ok)) begin
      blk_tmr <= 20'(network_relay_count) * 20'(blk);
    end else if (!relay_on) begin
      blk_tmr <= 20'h00000;
    end else if (blk_tmr != 20'h00000) begin
      blk_tmr <= blk_tmr - 20'h1;
    end
  end

  // ****************************************
  // timebases, address reply, events
  // ****************************************
  logic [31:0] tick_cnt, min_cnt;
  logic [11:0] mins;
  logic arp_pend;
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      tick_cnt <= 32'h0;
      min_cnt <= 32'h0;
      mins <= 12'h000;
      arp_pend <= 1'b1;
      arp_tx_o <= 1'b0;
    end else begin
      tick_cnt <= tick ? 32'h0 : tick_cnt + 32'h1;
      arp_pend <= 1'b0;
      arp_tx_o <= arp_pend;
      if (min_cnt == 32'(MIN_CYCLES - 1)) begin
        min_cnt <= 32'h0;
        if (mins + 12'h1 >= arp_min) begin
          mins <= 12'h000;
          arp_tx_o <= 1'b1;
        end else begin
          mins <= mins + 12'h1;
        end
      end else begin
        min_cnt <= min_cnt + 32'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      refused_o <= 1'b0;
      drop_o <= 1'b0;
      reject_cnt <= 8'h00;
    end else begin
      refused_o <= (relay_req || eth_take || |ser_take) && q_full;
      drop_o <= tmo_drop;
      if (tmo_drop && reject_cnt != 8'hff) begin
        reject_cnt <= reject_cnt + 8'h1;
      end
    end
  end

  // ****************************************
  // apb answer: one wait-free access phase
  // ****************************************
  always_comb begin
    unique case (paddr_i)
      rlf_pkg::A_CTRL: next_rdata = {4'h0, network_relay_count, 1'b0, qsize_kb, qlen,
        retries, 2'h0, fec_sel, strm_en, rpt_en, tmo_en, ack_en};
      rlf_pkg::A_TMO: next_rdata = {18'h0, tmo};
      rlf_pkg::A_ARP: next_rdata = {20'h0, arp_min};
      rlf_pkg::A_GAP: next_rdata = {byte_time, idle_gap};
      rlf_pkg::A_ACKW: next_rdata = {16'h0, ackw};
      rlf_pkg::A_BLK: next_rdata = {16'h0, blk};
      rlf_pkg::A_RATE: next_rdata = {user_rate, mod_rate};
      rlf_pkg::A_STAT: next_rdata = {reject_cnt, q_bytes[15:0], 3'h0, q_cnt};
      default: next_rdata = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
      prdata_o <= 32'h0;
    end else begin
      pready_o <= psel_i && !penable_i;
      pslverr_o <= psel_i && !penable_i && !addr_ok;
      if (psel_i && !penable_i) begin
        prdata_o <= next_rdata;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (srst_i);

  a_fec_off_rate: assert property (fec_sel == 2'h0 ##1 fec_sel == 2'h0 |-> user_rate == $past(mod_rate)) else $error("user rate wrong with correction off");
  a_no_ack_once: assert property (state == rlf_pkg::ST_SEND && tx_done_i && !ack_en |=> !tx_start_o ##1 state == rlf_pkg::ST_IDLE) else $error("frame repeated without ack");
  a_retry_fires: assert property (state == rlf_pkg::ST_ACKW && ack_tmr == 16'h0 && tries_left != 4'h0 && !ack_rx_i |=> tx_start_o && tries_left == $past(tries_left) - 4'h1) else $error("retry missing");
  a_full_refused: assert property (eth_valid_i && !relay_req && q_full |=> refused_o && q_cnt == $past(q_cnt) - 5'($past(pop))) else $error("full queue took frame");
  a_qlen_bound: assert property (q_cnt <= qlen || $past(apb_wr)) else $error("record limit exceeded");
  a_timeout_drop: assert property (tmo_drop |=> drop_o && q_cnt == $past(q_cnt) - 5'h1 + 5'($past(push))) else $error("timeout drop missing");
  a_arp_restart: assert property ($past(srst_i, 2) && !$past(srst_i) |-> arp_tx_o) else $error("no address reply after restart");
  a_crc_gate: assert property (rx_valid_i && !rx_crc_ok_i |=> !rx_ser_o && !rx_eth_o) else $error("bad frame handed on");
  a_block_hold: assert property (blk_tmr != 20'h0 && state == rlf_pkg::ST_IDLE |=> !tx_start_o) else $error("sent while blocked");
  a_no_relay_free: assert property (!relay_on |=> blk_tmr == 20'h0 || $past(relay_on)) else $error("blocking without relays");
endmodule

// [verification/rlf_radio_peer.sv]
// radio peer model: ends each frame after air time and may send an ack
module rlf_radio_peer (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  // radio side
  input wire logic tx_start_i,
  input wire logic ack_en_i,
  input wire logic stall_i,
  output logic tx_done_o,
  output logic ack_rx_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // air time and answer
  // ****************************************
  logic [2:0] cnt;
  logic busy;
  logic ack_due;
  // stall holds the frame on air so the queue can be filled meanwhile
  always_ff @(posedge sys_clk_i) begin
    tx_done_o <= 1'b0;
    ack_rx_o <= ack_due;
    ack_due <= 1'b0;
    if (srst_i) begin
      busy <= 1'b0;
      cnt <= 3'h0;
    end else if (tx_start_i) begin
      busy <= 1'b1;
      cnt <= 3'h3;
    end else if (busy && !stall_i) begin
      if (cnt == 3'h0) begin
        busy <= 1'b0;
        tx_done_o <= 1'b1;
        ack_due <= ack_en_i;
      end else begin
        cnt <= cnt - 3'h1;
      end
    end
  end
endmodule

// [verification/radio_link_frame_control_test.sv]
// register, queue, retry and receive tests of the radio link frame control
module radio_link_frame_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // signals
  // ****************************************
  logic sys_clk_i;
  logic srst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00, rx_byte_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
  logic pready_o, pslverr_o, err, eth_valid_i = 1'b0, tx_done_i, ack_rx_i, arp_tx_o;
  logic [15:0] eth_len_i = 16'h0, ser_data_i = 16'h0, rx_sig_i = 16'h0, rx_len_i = 16'h0;
  logic [1:0] ser_byte_valid_i = 2'h0;
  logic tx_start_o, rx_valid_i = 1'b0, rx_crc_ok_i = 1'b0, rx_local_i = 1'b0;
  logic rx_byte_valid_i = 1'b0, rx_eth_o, rx_ser_o, refused_o, ack_en = 1'b0, stall = 1'b0;
  int failures = 0, cmp_count = 0, n_start = 0, n_ref = 0, n_eth = 0, n_ser = 0, n_arp = 0;
  int n_drop = 0, n_abort = 0, n_sb = 0, n_sf = 0, n_so = 0;
  logic [15:0] tx_len_o, last_len;
  logic [1:0] tx_src_o, last_src, ser_out_valid_o;
  logic [7:0] ser_out_data_o, stream_data_o, last_sd, last_so;
  logic drop_o, stream_byte_o, stream_first_o, stream_abort_o;
  int s, e;
  logic [31:0] cfg [4] = '{32'h000a5201, 32'h000a5001, 32'h000a5200, 32'h000a5201};
  logic ae [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
  int es [4] = '{3, 1, 1, 1};
  logic [31:0] qcfg [2] = '{32'h000a2300, 32'h00025300};
  logic [15:0] qlen [2] = '{16'h0010, 16'h0258};
  logic crc [3] = '{1'b1, 1'b0, 1'b1};
  logic loc [3] = '{1'b1, 1'b1, 1'b0};
  int ee [3] = '{1, 0, 0};
  int se [3] = '{1, 0, 1};
  rlf_frame_ctrl #(.TICK_CYCLES(10), .MIN_CYCLES(20)) uut (
    .sys_clk_i, .srst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o,
    .pready_o, .pslverr_o, .eth_valid_i, .eth_len_i, .ser_byte_valid_i, .ser_data_i,
    .tx_start_o, .tx_len_o, .tx_src_o, .tx_done_i, .ack_rx_i, .arp_tx_o, .rx_valid_i,
    .rx_crc_ok_i, .rx_local_i, .rx_sig_i, .rx_len_i, .rx_byte_valid_i, .rx_byte_i,
    .rx_eth_o, .rx_ser_o, .ser_out_valid_o, .ser_out_data_o, .stream_byte_o,
    .stream_first_o, .stream_data_o, .stream_abort_o, .refused_o, .drop_o
  );
  rlf_radio_peer peer (
    .sys_clk_i, .srst_i, .tx_start_i(tx_start_o), .ack_en_i(ack_en), .stall_i(stall),
    .tx_done_o(tx_done_i), .ack_rx_o(ack_rx_i)
  );
  // ****************************************
  // clock, event counters and tasks
  // ****************************************
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (tx_start_o === 1'b1) begin
      n_start++;
      last_len = tx_len_o;
      last_src = tx_src_o;
    end
    if (refused_o === 1'b1) n_ref++;
    if (rx_eth_o === 1'b1) n_eth++;
    if (rx_ser_o === 1'b1) n_ser++;
    if (arp_tx_o === 1'b1) n_arp++;
    if (drop_o === 1'b1) n_drop++;
    if (stream_abort_o === 1'b1) n_abort++;
    if (stream_byte_o === 1'b1) begin
      n_sb++;
      last_sd = stream_data_o;
      if (stream_first_o === 1'b1) n_sf++;
    end
    if (ser_out_valid_o === 2'b11) begin
      n_so++;
      last_so = ser_out_data_o;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
    end while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic offer(input int k, input logic [15:0] len);
    repeat (k) begin
      @(posedge sys_clk_i);
      eth_valid_i <= 1'b1;
      eth_len_i <= len;
    end
    @(posedge sys_clk_i);
    eth_valid_i <= 1'b0;
  endtask
  task automatic rx(input logic c, input logic l, input logic [15:0] sg);
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b1;
    rx_crc_ok_i <= c;
    rx_local_i <= l;
    rx_sig_i <= sg;
    @(posedge sys_clk_i);
    rx_valid_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic sbyte(input logic [1:0] v, input logic [15:0] d);
    @(posedge sys_clk_i);
    ser_byte_valid_i <= v;
    ser_data_i <= d;
    @(posedge sys_clk_i);
    ser_byte_valid_i <= 2'b00;
  endtask
  // polls the record count rather than guessing how long retries take
  task automatic drain;
    do begin
      apb(1'b0, rlf_pkg::A_STAT, 32'h0);
    end while (rd[4:0] !== 5'h00);
    repeat (4) @(posedge sys_clk_i);
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    failures++;
    wrap_up();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk_i);
    srst_i <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
    chk(n_arp, 1);
    apb(1'b0, rlf_pkg::A_CTRL, 32'h0);
    chk(rd, 32'h000a5301);
    apb(1'b0, rlf_pkg::A_TMO, 32'h0);
    chk(rd, 32'h000001f4);
    apb(1'b0, rlf_pkg::A_ARP, 32'h0);
    chk(rd, 32'h000005a0);
    apb(1'b0, 8'h20, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, rlf_pkg::A_CTRL, 32'h000a5331);
    apb(1'b0, rlf_pkg::A_RATE, 32'h0);
    chk(rd, 32'h00200040);
    apb(1'b1, rlf_pkg::A_ACKW, 32'h8);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, rlf_pkg::A_CTRL, cfg[i]);
      ack_en <= ae[i];
      s = n_start;
      offer(1, 16'h0040);
      drain();
      chk(n_start - s, es[i]);
    end
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, rlf_pkg::A_CTRL, qcfg[i]);
      stall <= 1'b1;
      s = n_ref;
      offer(3, qlen[i]);
      repeat (3) @(posedge sys_clk_i);
      chk(n_ref - s, 1);
      apb(1'b0, rlf_pkg::A_STAT, 32'h0);
      chk(rd[4:0], 5'h02);
      stall <= 1'b0;
      drain();
    end
    for (int i = 0; i < 3; i++) begin
      e = n_eth;
      s = n_ser;
      rx(crc[i], loc[i], 16'(i));
      chk(n_eth - e, ee[i]);
      chk(n_ser - s, se[i]);
    end
    // repeater: a received frame goes back on air as a relay record
    rx_len_i <= 16'h0020;
    apb(1'b1, rlf_pkg::A_CTRL, 32'h000a5304);
    rx(1'b1, 1'b0, 16'h0100);
    drain();
    chk(last_src, 2'h3);
    chk(last_len, 16'h0020);
    // one relay in the net: duplicate dropped, transmit blocked, head times out
    apb(1'b1, rlf_pkg::A_TMO, 32'h1);
    apb(1'b1, rlf_pkg::A_CTRL, 32'h010a5302);
    s = n_ser;
    rx(1'b1, 1'b0, 16'h0055);
    rx(1'b1, 1'b0, 16'h0055);
    chk(n_ser - s, 1);
    s = n_start;
    offer(1, 16'h0040);
    repeat (40) @(posedge sys_clk_i);
    chk(n_start - s, 0);
    chk(n_drop, 1);
    apb(1'b0, rlf_pkg::A_STAT, 32'h0);
    chk(rd, 32'h01000000);
    apb(1'b1, rlf_pkg::A_CTRL, 32'h000a5300);
    s = n_start;
    offer(1, 16'h0040);
    drain();
    chk(n_start - s, 1);
    // idle framing on serial port two, then stream mode
    apb(1'b1, rlf_pkg::A_GAP, 32'h00080010);
    sbyte(2'b10, 16'h4400);
    sbyte(2'b10, 16'h4400);
    repeat (30) @(posedge sys_clk_i);
    chk(last_len, 16'h0002);
    chk(last_src, 2'h2);
    apb(1'b1, rlf_pkg::A_CTRL, 32'h000a5308);
    sbyte(2'b01, 16'h00a5);
    sbyte(2'b10, 16'h3c00);
    offer(1, 16'h0040);
    repeat (12) @(posedge sys_clk_i);
    sbyte(2'b01, 16'h0077);
    @(posedge sys_clk_i);
    rx_byte_valid_i <= 1'b1;
    rx_byte_i <= 8'h5a;
    @(posedge sys_clk_i);
    rx_byte_valid_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    chk(n_sb, 3);
    chk(n_sf, 2);
    chk(last_sd, 8'h77);
    chk(n_abort, 1);
    chk(n_so, 1);
    chk(last_so, 8'h5a);
    drain();
    wrap_up();
  end
endmodule
